/* File: core/crs_map.vh */
// constants for the cpu register set: indices, encodings, reset values
`ifndef CRS_MAP_VH
`define CRS_MAP_VH

// general register indices (word view)
`define CRS_GP_ACC 3'h0
`define CRS_GP_COUNT 3'h1
`define CRS_GP_DEXT 3'h2
`define CRS_GP_BASE 3'h3
`define CRS_GP_STACK 3'h4
`define CRS_GP_FRAME 3'h5
`define CRS_GP_SRC 3'h6
`define CRS_GP_DEST 3'h7

// byte view: bit 2 picks the high half, bits 1..0 the word register
`define CRS_BYTE_HI_BIT 2
`define CRS_BYTE_HI_MSB 15
`define CRS_BYTE_HI_LSB 8
`define CRS_BYTE_LO_MSB 7
`define CRS_BYTE_LO_LSB 0

// general write size
`define CRS_SIZE_WORD 1'h0
`define CRS_SIZE_BYTE 1'h1

// segment selector indices
`define CRS_SEG_EXTRA 2'h0
`define CRS_SEG_CODE 2'h1
`define CRS_SEG_STACK 2'h2
`define CRS_SEG_DATA 2'h3

// address generation modes
`define CRS_AG_DIRECT 3'h0
`define CRS_AG_BASE 3'h1
`define CRS_AG_SRC 3'h2
`define CRS_AG_DEST 3'h3
`define CRS_AG_STACK 3'h4
`define CRS_AG_FRAME 3'h5
`define CRS_AG_FRAME_SRC 3'h6
`define CRS_AG_BASE_SRC 3'h7

// stack step in bytes per word item
`define CRS_STACK_STEP 16'h0002
// real mode paragraph shift
`define CRS_PARA_PAD 4'h0

// reset values
`define CRS_GP_RST 16'h0000
`define CRS_SEG_RST 16'h0000
`define CRS_IP_RST 16'h0000
`define CRS_FLAGS_RST 16'h0000

`endif

/* File: core/crs_register_set.v */
// cpu register set: general, segment, pointer and flags registers with address forming
`include "crs_map.vh"

module crs_register_set
(
    input wire sys_clk_in,
    input wire rstn_in,
    input wire gp_wr_en_in,
    input wire gp_wr_size_in,
    input wire [2:0] gp_wr_sel_in,
    input wire [15:0] gp_wr_data_in,
    input wire [2:0] gp_rd_sel_in,
    input wire [2:0] byte_rd_sel_in,
    input wire seg_wr_en_in,
    input wire [1:0] seg_wr_sel_in,
    input wire [15:0] seg_wr_data_in,
    input wire [1:0] seg_rd_sel_in,
    input wire xfer_en_in,
    input wire xfer_far_in,
    input wire [15:0] xfer_sel_in,
    input wire [15:0] xfer_off_in,
    input wire ip_adv_en_in,
    input wire [3:0] ip_adv_len_in,
    input wire push_in,
    input wire pop_in,
    input wire flags_wr_en_in,
    input wire [15:0] flags_wr_data_in,
    input wire prot_mode_in,
    input wire [2:0] agen_mode_in,
    input wire agen_str_dest_in,
    input wire [15:0] agen_disp_in,
    output reg [15:0] gp_rd_out,
    output reg [7:0] byte_rd_out,
    output reg [15:0] seg_rd_out,
    output reg seg_refused_out,
    output reg [31:0] fetch_ptr_out,
    output reg [19:0] fetch_phys_out,
    output reg [31:0] stack_ptr_out,
    output reg stack_valid_out,
    output reg [31:0] agen_ptr_out,
    output reg [19:0] agen_phys_out,
    output reg agen_xlate_out,
    output reg [15:0] flags_out
);

    // flattened general words, entry i at bits 16*i+15..16*i
    wire [127:0] gp_flat;
    // flattened segment selectors, same packing
    wire [63:0] seg_flat;
    // instruction offset pointer
    reg [15:0] instr_offset_ptr;
    // flags word, the second status register
    reg [15:0] flags;
    // single stack operation this cycle; both at once is ignored
    wire do_push;
    wire do_pop;
    // explicit selector load that is allowed
    wire seg_load_ok;

    assign do_push = push_in & ~pop_in;
    assign do_pop = pop_in & ~push_in;
    // code selector never takes an explicit load
    assign seg_load_ok = seg_wr_en_in & (seg_wr_sel_in != `CRS_SEG_CODE);

    // named views of the general registers
    wire [15:0] accumulator_word;
    wire [15:0] count_word;
    wire [15:0] data_ext_word;
    wire [15:0] base_data_word;
    wire [15:0] stack_top_ptr;
    wire [15:0] frame_base_ptr;
    wire [15:0] src_index;
    wire [15:0] dest_index;
    assign accumulator_word = gp_flat[16*0 +: 16];
    assign count_word = gp_flat[16*1 +: 16];
    assign data_ext_word = gp_flat[16*2 +: 16];
    assign base_data_word = gp_flat[16*3 +: 16];
    assign stack_top_ptr = gp_flat[16*4 +: 16];
    assign frame_base_ptr = gp_flat[16*5 +: 16];
    assign src_index = gp_flat[16*6 +: 16];
    assign dest_index = gp_flat[16*7 +: 16];

    // named views of the segment selectors
    wire [15:0] extra_seg_sel;
    wire [15:0] code_seg_sel;
    wire [15:0] stack_seg_sel;
    wire [15:0] data_seg_sel;
    assign extra_seg_sel = seg_flat[16*0 +: 16];
    assign code_seg_sel = seg_flat[16*1 +: 16];
    assign stack_seg_sel = seg_flat[16*2 +: 16];
    assign data_seg_sel = seg_flat[16*3 +: 16];

    genvar gi;
    generate
        // one general word register per entry
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_gp
            reg [15:0] word_q; // stored word
            reg [15:0] next_word; // value for next edge
            wire word_hit; // full word write
            wire lo_hit; // low byte write
            wire hi_hit; // high byte write
            assign word_hit = gp_wr_en_in & (gp_wr_size_in == `CRS_SIZE_WORD)
                & (gp_wr_sel_in == gi);
            // only the first four words have byte views
            assign lo_hit = (gi < 4) & gp_wr_en_in & (gp_wr_size_in == `CRS_SIZE_BYTE)
                & ~gp_wr_sel_in[`CRS_BYTE_HI_BIT] & (gp_wr_sel_in[1:0] == gi);
            assign hi_hit = (gi < 4) & gp_wr_en_in & (gp_wr_size_in == `CRS_SIZE_BYTE)
                & gp_wr_sel_in[`CRS_BYTE_HI_BIT] & (gp_wr_sel_in[1:0] == gi);

            // next value: stack step wins on the stack pointer
            always @*
            begin
                next_word = word_q;
                if ((gi == `CRS_GP_STACK) && do_push)
                begin
                    next_word = word_q - `CRS_STACK_STEP;
                end
                else if ((gi == `CRS_GP_STACK) && do_pop)
                begin
                    next_word = word_q + `CRS_STACK_STEP;
                end
                else if (word_hit)
                begin
                    next_word = gp_wr_data_in;
                end
                else if (lo_hit)
                begin
                    // upper half untouched
                    next_word = {word_q[`CRS_BYTE_HI_MSB:`CRS_BYTE_HI_LSB],
                        gp_wr_data_in[`CRS_BYTE_LO_MSB:`CRS_BYTE_LO_LSB]};
                end
                else if (hi_hit)
                begin
                    // lower half untouched
                    next_word = {gp_wr_data_in[`CRS_BYTE_LO_MSB:`CRS_BYTE_LO_LSB],
                        word_q[`CRS_BYTE_LO_MSB:`CRS_BYTE_LO_LSB]};
                end
            end

            // word storage
            always @(posedge sys_clk_in)
            begin
                if (!rstn_in)
                begin
                    word_q <= `CRS_GP_RST;
                end
                else
                begin
                    word_q <= next_word;
                end
            end
            assign gp_flat[16*gi +: 16] = word_q;
        end

        // one selector register per segment
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_seg
            reg [15:0] sel_q; // stored selector
            always @(posedge sys_clk_in)
            begin
                if (!rstn_in)
                begin
                    sel_q <= `CRS_SEG_RST;
                end
                else if ((gi == `CRS_SEG_CODE) && xfer_en_in && xfer_far_in)
                begin
                    // code selector changes only through a transfer
                    sel_q <= xfer_sel_in;
                end
                else if (seg_load_ok && (seg_wr_sel_in == gi))
                begin
                    sel_q <= seg_wr_data_in;
                end
            end
            assign seg_flat[16*gi +: 16] = sel_q;
        end
    endgenerate

    // instruction offset pointer and flags, the status group
    always @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            instr_offset_ptr <= `CRS_IP_RST;
            flags <= `CRS_FLAGS_RST;
        end
        else
        begin
            // transfer beats sequential advance
            if (xfer_en_in)
            begin
                instr_offset_ptr <= xfer_off_in;
            end
            else if (ip_adv_en_in)
            begin
                instr_offset_ptr <= instr_offset_ptr + {12'h000, ip_adv_len_in};
            end
            if (flags_wr_en_in)
            begin
                flags <= flags_wr_data_in;
            end
        end
    end

    // address forming: offset and default segment
    reg [15:0] ag_off;
    reg [15:0] ag_sel;
    always @*
    begin
        ag_off = agen_disp_in;
        ag_sel = data_seg_sel;
        case (agen_mode_in)
            `CRS_AG_DIRECT:
            begin
                ag_off = agen_disp_in;
            end
            `CRS_AG_BASE:
            begin
                ag_off = base_data_word + agen_disp_in;
            end
            `CRS_AG_SRC:
            begin
                ag_off = src_index + agen_disp_in;
            end
            `CRS_AG_DEST:
            begin
                ag_off = dest_index + agen_disp_in;
                // string destinations go to the extra segment
                if (agen_str_dest_in)
                begin
                    ag_sel = extra_seg_sel;
                end
            end
            `CRS_AG_STACK:
            begin
                ag_off = stack_top_ptr + agen_disp_in;
                ag_sel = stack_seg_sel;
            end
            `CRS_AG_FRAME:
            begin
                ag_off = frame_base_ptr + agen_disp_in;
                ag_sel = stack_seg_sel;
            end
            `CRS_AG_FRAME_SRC:
            begin
                ag_off = frame_base_ptr + src_index + agen_disp_in;
                ag_sel = stack_seg_sel;
            end
            `CRS_AG_BASE_SRC:
            begin
                ag_off = base_data_word + src_index + agen_disp_in;
            end
            default:
            begin
                ag_off = agen_disp_in;
            end
        endcase
    end

    // stack access offset: new top on push, old top on pop
    wire [15:0] stk_off;
    assign stk_off = do_push ? (stack_top_ptr - `CRS_STACK_STEP) : stack_top_ptr;

    // registered read ports and pointers
    always @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            gp_rd_out <= 16'h0000;
            byte_rd_out <= 8'h00;
            seg_rd_out <= 16'h0000;
            seg_refused_out <= 1'b0;
            fetch_ptr_out <= 32'h00000000;
            fetch_phys_out <= 20'h00000;
            stack_ptr_out <= 32'h00000000;
            stack_valid_out <= 1'b0;
            agen_ptr_out <= 32'h00000000;
            agen_phys_out <= 20'h00000;
            agen_xlate_out <= 1'b0;
            flags_out <= `CRS_FLAGS_RST;
        end
        else
        begin
            gp_rd_out <= gp_flat[16*gp_rd_sel_in +: 16];
            // byte view: high or low half of one of the first four words
            if (byte_rd_sel_in[`CRS_BYTE_HI_BIT])
            begin
                byte_rd_out <= gp_flat[16*byte_rd_sel_in[1:0] + 8 +: 8];
            end
            else
            begin
                byte_rd_out <= gp_flat[16*byte_rd_sel_in[1:0] +: 8];
            end
            seg_rd_out <= seg_flat[16*seg_rd_sel_in +: 16];
            // pulse on a refused code selector load
            seg_refused_out <= seg_wr_en_in & (seg_wr_sel_in == `CRS_SEG_CODE);
            fetch_ptr_out <= {code_seg_sel, instr_offset_ptr};
            stack_ptr_out <= {stack_seg_sel, stk_off};
            stack_valid_out <= do_push | do_pop;
            agen_ptr_out <= {ag_sel, ag_off};
            // real mode: selector is the paragraph base; protected: translate
            if (prot_mode_in)
            begin
                agen_phys_out <= 20'h00000;
                fetch_phys_out <= 20'h00000;
                agen_xlate_out <= 1'b1;
            end
            else
            begin
                agen_phys_out <= {ag_sel, `CRS_PARA_PAD} + {4'h0, ag_off};
                fetch_phys_out <= {code_seg_sel, `CRS_PARA_PAD}
                    + {4'h0, instr_offset_ptr};
                agen_xlate_out <= 1'b0;
            end
            flags_out <= flags;
        end
    end

endmodule

/* File: sim/crs_exec_model.sv */
// execution unit model: steps the instruction offset while running
module crs_exec_model
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic run_in,
    output logic ip_adv_en_out,
    output logic [3:0] ip_adv_len_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // fixed three byte instructions, one per cycle
    assign ip_adv_len_out = 4'h3;
    always @(posedge sys_clk_in)
    begin
        ip_adv_en_out <= run_in && rstn_in;
    end
endmodule

/* File: sim/crs_props.sv */
// checker: port-level properties of the cpu register set
module crs_props
(
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic seg_wr_en_in,
    input wire logic [1:0] seg_wr_sel_in,
    input wire logic seg_refused_out,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic stack_valid_out,
    input wire logic [31:0] stack_ptr_out,
    input wire logic [31:0] fetch_ptr_out,
    input wire logic [19:0] fetch_phys_out,
    input wire logic prot_mode_in,
    input wire logic agen_xlate_out,
    input wire logic [31:0] agen_ptr_out,
    input wire logic [19:0] agen_phys_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    // code selector loads must be refused
    a_code_refused: assert property (seg_wr_en_in && seg_wr_sel_in == 2'h1 |=> seg_refused_out)
        else $error("code selector load not refused");
    a_refused_cause: assert property (seg_refused_out |-> $past(seg_wr_sel_in) == 2'h1)
        else $error("refusal without a code selector load");
    // lone push or pop gives a valid pulse
    a_stack_valid: assert property (push_in != pop_in |=> stack_valid_out)
        else $error("stack op without valid pulse");
    a_both_ignored: assert property (push_in && pop_in |=> !stack_valid_out)
        else $error("push with pop not ignored");
    // pop right after push reads back the pushed top
    a_push_pop: assert property (push_in && !pop_in ##1 pop_in && !push_in
        |=> stack_ptr_out[15:0] == $past(stack_ptr_out[15:0]))
        else $error("pop offset differs from pushed top");
    // real mode physical address from the pointer
    a_fetch_phys: assert property (!agen_xlate_out |-> fetch_phys_out
        == {fetch_ptr_out[31:16], 4'h0} + {4'h0, fetch_ptr_out[15:0]})
        else $error("fetch physical address wrong");
    a_agen_real: assert property (!agen_xlate_out |-> agen_phys_out
        == {agen_ptr_out[31:16], 4'h0} + {4'h0, agen_ptr_out[15:0]})
        else $error("operand physical address wrong");
    // protected mode defers to translation
    a_agen_xlate: assert property (prot_mode_in |=> agen_xlate_out)
        else $error("protected mode without translation flag");
    a_prot_phys: assert property (agen_xlate_out |-> agen_phys_out == 20'h00000
        && fetch_phys_out == 20'h00000)
        else $error("physical address given in protected mode");
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the cpu register set
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in, rstn_in, gp_wr_en_in, gp_wr_size_in, seg_wr_en_in, xfer_en_in;
    logic xfer_far_in, push_in, pop_in, flags_wr_en_in, prot_mode_in, agen_str_dest_in;
    logic ip_adv_en_in, exec_run, seg_refused_out, stack_valid_out, agen_xlate_out;
    logic [2:0] gp_wr_sel_in, gp_rd_sel_in, byte_rd_sel_in, agen_mode_in;
    logic [1:0] seg_wr_sel_in, seg_rd_sel_in;
    logic [3:0] ip_adv_len_in;
    logic [7:0] byte_rd_out;
    logic [15:0] gp_wr_data_in, seg_wr_data_in, xfer_sel_in, xfer_off_in, flags_wr_data_in;
    logic [15:0] agen_disp_in, gp_rd_out, seg_rd_out, flags_out;
    logic [19:0] fetch_phys_out, agen_phys_out;
    logic [31:0] fetch_ptr_out, stack_ptr_out, agen_ptr_out;
    int error_cnt, samples_checked, i;
    // word write data per register index, read back unchanged
    logic [15:0] rows [8] = '{16'h1234, 16'h5678, 16'h9ABC, 16'h0020, 16'h0100,
        16'h0200, 16'h0300, 16'h0040};
    crs_register_set dut (.sys_clk_in, .rstn_in, .gp_wr_en_in, .gp_wr_size_in,
        .gp_wr_sel_in, .gp_wr_data_in, .gp_rd_sel_in, .byte_rd_sel_in, .seg_wr_en_in,
        .seg_wr_sel_in, .seg_wr_data_in, .seg_rd_sel_in, .xfer_en_in, .xfer_far_in,
        .xfer_sel_in, .xfer_off_in, .ip_adv_en_in, .ip_adv_len_in, .push_in, .pop_in,
        .flags_wr_en_in, .flags_wr_data_in, .prot_mode_in, .agen_mode_in,
        .agen_str_dest_in, .agen_disp_in, .gp_rd_out, .byte_rd_out, .seg_rd_out,
        .seg_refused_out, .fetch_ptr_out, .fetch_phys_out, .stack_ptr_out,
        .stack_valid_out, .agen_ptr_out, .agen_phys_out, .agen_xlate_out, .flags_out);
    crs_exec_model u_exec (.sys_clk_in, .rstn_in, .run_in(exec_run),
        .ip_adv_en_out(ip_adv_en_in), .ip_adv_len_out(ip_adv_len_in));
    // compare and count
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // let registered outputs settle
    task settle;
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask
    task gp_wr(input logic size, input logic [2:0] sel, input logic [15:0] data);
        @(posedge sys_clk_in);
        {gp_wr_en_in, gp_wr_size_in, gp_wr_sel_in, gp_wr_data_in} <= {1'h1, size, sel, data};
        @(posedge sys_clk_in);
        gp_wr_en_in <= 1'h0;
    endtask
    task agen(input logic [3:0] mode, input logic [31:0] exp);
        @(posedge sys_clk_in);
        {agen_str_dest_in, agen_mode_in} <= mode;
        settle();
        chk("agen ptr", agen_ptr_out, exp);
        chk("agen phys", agen_phys_out, {exp[31:16], 4'h0} + exp[15:0]);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        sys_clk_in = 1'h0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    // watchdog: the run needs well under 400 cycles
    initial
    begin
        #50000;
        error_cnt++;
        finish_test();
    end
    initial
    begin
        {rstn_in, gp_wr_en_in, gp_wr_size_in, seg_wr_en_in, xfer_en_in, xfer_far_in} = 0;
        {push_in, pop_in, flags_wr_en_in, prot_mode_in, agen_str_dest_in, exec_run} = 0;
        {gp_wr_sel_in, gp_rd_sel_in, byte_rd_sel_in, agen_mode_in, seg_wr_sel_in} = 0;
        {seg_rd_sel_in, gp_wr_data_in, seg_wr_data_in, xfer_sel_in, xfer_off_in} = 0;
        flags_wr_data_in = 16'h0000;
        agen_disp_in = 16'h0002;
        repeat (2) @(posedge sys_clk_in);
        rstn_in <= 1'h1;
        settle();
        chk("gp reset", gp_rd_out, 32'h0);
        // ordinary cases: word write then read of every general register
        for (i = 0; i < 8; i++)
            gp_wr(1'h0, i[2:0], rows[i]);
        for (i = 0; i < 8; i++)
        begin
            gp_rd_sel_in <= i[2:0];
            settle();
            chk("gp word", gp_rd_out, rows[i]);
        end
        // byte writes keep the other half
        gp_wr(1'h1, 3'h4, 16'h00AB);
        gp_wr(1'h1, 3'h1, 16'h00CD);
        gp_rd_sel_in <= 3'h0;
        byte_rd_sel_in <= 3'h4;
        settle();
        chk("acc word", gp_rd_out, {16'h0, 8'hAB, rows[0][7:0]});
        chk("acc high", byte_rd_out, 32'hAB);
        gp_rd_sel_in <= 3'h1;
        byte_rd_sel_in <= 3'h1;
        settle();
        chk("count word", gp_rd_out, {16'h0, rows[1][15:8], 8'hCD});
        chk("count low", byte_rd_out, 32'hCD);
        // selector loads; the code selector refuses
        for (i = 0; i < 4; i++)
        begin
            @(posedge sys_clk_in);
            {seg_wr_en_in, seg_wr_sel_in, seg_wr_data_in} <= {1'h1, i[1:0], 16'((i + 1) * 16'h1000)};
            @(posedge sys_clk_in);
            seg_wr_en_in <= 1'h0;
            #1;
            chk("refused", seg_refused_out, i == 1);
            seg_rd_sel_in <= i[1:0];
            settle();
            chk("selector", seg_rd_out, (i == 1) ? 0 : 16'h1000 * (i + 1));
        end
        // push, pop, then both at once
        @(posedge sys_clk_in);
        push_in <= 1'h1;
        @(posedge sys_clk_in);
        {push_in, pop_in} <= 2'h1;
        #1;
        chk("push", stack_ptr_out, {16'h3000, rows[4] - 16'h2});
        chk("push valid", stack_valid_out, 32'h1);
        @(posedge sys_clk_in);
        {push_in, pop_in} <= 2'h3;
        #1;
        chk("pop", stack_ptr_out, {16'h3000, rows[4] - 16'h2});
        chk("pop valid", stack_valid_out, 32'h1);
        @(posedge sys_clk_in);
        {push_in, pop_in} <= 2'h0;
        #1;
        chk("push pop", stack_valid_out, 32'h0);
        gp_rd_sel_in <= 3'h4;
        settle();
        chk("stack top", gp_rd_out, rows[4]);
        // implicit segment choice per addressing mode
        agen(4'h4, {16'h3000, rows[4] + 16'h2});
        agen(4'h1, {16'h4000, rows[3] + 16'h2});
        agen(4'h3, {16'h4000, rows[7] + 16'h2});
        agen(4'hB, {16'h1000, rows[7] + 16'h2});
        agen(4'h0, {16'h4000, 16'h0002});
        agen(4'h2, {16'h4000, rows[6] + 16'h2});
        agen(4'h5, {16'h3000, rows[5] + 16'h2});
        agen(4'h6, {16'h3000, rows[5] + rows[6] + 16'h2});
        agen(4'h7, {16'h4000, rows[3] + rows[6] + 16'h2});
        prot_mode_in <= 1'h1;
        settle();
        chk("xlate", {agen_xlate_out, agen_phys_out}, {1'h1, 20'h0});
        chk("fetch xlate", fetch_phys_out, 32'h0);
        // far transfer in real mode then four sequential fetches
        @(posedge sys_clk_in);
        prot_mode_in <= 1'h0;
        {xfer_en_in, xfer_far_in, xfer_sel_in, xfer_off_in} <= {2'h3, 16'h0F00, 16'h0010};
        @(posedge sys_clk_in);
        xfer_en_in <= 1'h0;
        exec_run <= 1'h1;
        repeat (4) @(posedge sys_clk_in);
        exec_run <= 1'h0;
        seg_rd_sel_in <= 2'h1;
        settle();
        chk("fetch ptr", fetch_ptr_out, 32'h0F00001C);
        chk("fetch phys", fetch_phys_out, 32'h0F01C);
        chk("code sel", seg_rd_out, 32'h0F00);
        @(posedge sys_clk_in);
        {flags_wr_en_in, flags_wr_data_in} <= {1'h1, 16'h0ABC};
        // near transfer alongside: offset moves, code selector stays
        {xfer_en_in, xfer_far_in, xfer_sel_in, xfer_off_in} <= {2'h2, 16'h0A00, 16'h0040};
        @(posedge sys_clk_in);
        flags_wr_en_in <= 1'h0;
        xfer_en_in <= 1'h0;
        settle();
        chk("flags", flags_out, 32'h0ABC);
        chk("near xfer", fetch_ptr_out, 32'h0F000040);
        // mid-run reset clears every register
        @(posedge sys_clk_in);
        rstn_in <= 1'h0;
        @(posedge sys_clk_in);
        rstn_in <= 1'h1;
        settle();
        chk("reset fetch", fetch_ptr_out, 32'h0);
        chk("reset flags", flags_out, 32'h0);
        chk("reset sel", seg_rd_out, 32'h0);
        chk("reset top", gp_rd_out, 32'h0);
        finish_test();
    end
endmodule
bind crs_register_set crs_props u_props (.sys_clk_in, .rstn_in, .seg_wr_en_in,
    .seg_wr_sel_in, .seg_refused_out, .push_in, .pop_in, .stack_valid_out, .stack_ptr_out,
    .fetch_ptr_out, .fetch_phys_out, .prot_mode_in, .agen_xlate_out, .agen_ptr_out,
    .agen_phys_out);
